// ### core/glomc_top.v
// Genlock offset and mode control: offset pipe, mode machine, APB registers.
// Assumes ref pins are asynchronous; APB and all logic on clk_sys.
`timescale 1ns/1ps
`include "glomc_defs.vh"

module glomc_top (
	input  wire        clk_sys,          // System / pixel clock
	input  wire        resetn,           // Synchronous reset, active low
	input  wire        clk_en,           // Freezes all state while low
	input  wire        pclk_en,          // Pixel clock strobe, on clk_sys
	input  wire        ref_hsync,        // Reference line pulse (pin)
	input  wire        ref_vsync,        // Reference frame pulse (pin)
	input  wire        ref_fmt_valid,    // Reference format recognised
	input  wire [5:0]  ref_fmt,          // Detected reference format
	input  wire        lock_req_n,       // Lock-request pin, low requests lock
	input  wire [5:0]  output_format_select, // Format select pins
	input  wire [2:0]  audio_rate_select,    // Audio rate select pins
	input  wire [15:0] sae_count_in,     // Sync-to-active-end count of format
	input  wire [9:0]  paddr,            // APB byte address, word aligned
	input  wire        psel,             // APB select
	input  wire        penable,          // APB enable
	input  wire        pwrite,           // APB direction
	input  wire [31:0] pwdata,           // APB write data
	output wire        pready,           // APB ready
	output reg  [31:0] prdata,           // APB read data
	output wire        pslverr,          // APB error
	output reg         out_hsync,        // Delayed line timing
	output reg         out_vsync,        // Delayed frame timing
	output reg  [8:0]  phase_steps,      // Sub-pixel delay steps
	output reg  [1:0]  phase_scale,      // 0:1/512 1:1/256 2:1/128 3:1/64
	output reg  [1:0]  clk_source,       // 0 crystal,1 reference,2 hold
	output reg  [5:0]  active_format,    // Format being generated
	output reg         use_defaults,     // Outputs follow internal defaults
	output reg  [2:0]  audio_rate,       // Active audio rate select
	output reg         audio_lock_video  // Audio dividers track video clock
);

	// Mode states
	localparam [2:0] ST_START  = 3'd0;
	localparam [2:0] ST_FREE   = 3'd1;
	localparam [2:0] ST_LOCK   = 3'd2;
	localparam [2:0] ST_HOLD   = 3'd3;
	localparam [2:0] ST_WAIT   = 3'd4;

	localparam integer LOSS_CYC = (`GLOMC_LOSS_NS * `GLOMC_CLK_MHZ) / 1000;

	// Synchronisers: first stage only feeds second
	reg  [2:0]  hs_s1_r, hs_s2_r;      // hsync, vsync, lock_req_n
	reg         hs_d_r;                // Previous hsync for edge
	reg         vs_d_r;                // Previous vsync for edge
	wire        h_edge = hs_s2_r[0] & ~hs_d_r;
	wire        v_edge = hs_s2_r[1] & ~vs_d_r;
	wire        lockreq = ~hs_s2_r[2];

	// Registers
	reg  [15:0] line_delay_pixels_r;   // Horizontal offset
	reg  [15:0] frame_delay_lines_r;   // Vertical offset
	reg  [15:0] subpixel_phase_shift_r; // Phase word
	reg  [2:0]  ctrl_r;                // Ref type, lock mask, cross-lock
	reg  [1:0]  custom_r;              // Custom timing / clock written
	reg  [2:0]  state_r, state_nxt;    // Mode state
	reg  [17:0] loss_cnt_r;            // Cycles since last line
	reg  [15:0] hcnt_r;                // Pixel count since ref line
	reg         hpend_r;               // Line delay running
	reg  [15:0] vcnt_r;                // Line count since ref frame
	reg         vpend_r;               // Frame delay running
	reg  [1:0]  fix_r;                 // Fixed two pixel pipe
	reg         vlock_r;               // Vertical lock seen

	wire        ref_ok = (loss_cnt_r < LOSS_CYC[17:0]);
	wire [15:0] sae_thr = sae_count_in + `GLOMC_HTHRESH;
	// Horizontal threshold by reference type
	wire [15:0] hthr = ctrl_r[`GLOMC_CT_BLANKREF] ? sae_thr : `GLOMC_HTHRESH;
	// Lock flag dip at exact threshold unless masked
	wire        dip = (line_delay_pixels_r == hthr) & ~ctrl_r[`GLOMC_CT_MASKLOCK]; // see R09 see R10
	reg  [5:0]  fmt_s1_r, fmt_s2_r;    // Format select pins, two stages
	reg  [2:0]  asr_s1_r, asr_s2_r;    // Audio rate pins, two stages
	wire [5:0]  fmt = fmt_s2_r;        // Synchronised format select

	// Select pin synchronisers; pins may move at any time, so the mode
	// machine never sees a half-settled code. Left unreset: the reset
	// time fills them, and the start state then sees the real pins.
	always @(posedge clk_sys)
	begin
		if (clk_en)
		begin
			fmt_s1_r <= output_format_select;
			fmt_s2_r <= fmt_s1_r;
			asr_s1_r <= audio_rate_select;
			asr_s2_r <= asr_s1_r;
		end
	end
	wire        no_adv = (fmt == 6'd4) | (fmt == 6'd6) | (fmt == 6'd8);

	// Effective vertical line target, in lines after ref frame
	reg  [15:0] vtarget;
	always @*
	begin
		vtarget = frame_delay_lines_r;
		// Built-in one line advance
		if (!no_adv)                                  // see R07
			vtarget = vtarget - 16'h0001;
		// Large line offset advances by one more line
		if (line_delay_pixels_r > hthr)               // see R09 see R10
			vtarget = vtarget - 16'h0001;
		// Cross-lock skew modelled as one line of delay
		if (ctrl_r[`GLOMC_CT_XLOCK])                  // see R08
			vtarget = vtarget + 16'h0001;
	end

	// APB: zero wait, no error
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	wire wr = psel & penable & pwrite & clk_en;
	// Word index; an unaligned address matches no register
	wire [7:0]  widx = (paddr[1:0] == 2'b00) ? paddr[9:2] : 8'hFF;

	// Register writes
	always @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			line_delay_pixels_r    <= 16'h0000;
			frame_delay_lines_r    <= 16'h0000;
			subpixel_phase_shift_r <= 16'h0000;
			ctrl_r                 <= 3'b000;
			custom_r               <= 2'b00;
		end
		else if (wr)
		begin
			case (widx)
				`GLOMC_IDX_LINEDLY:  line_delay_pixels_r <= pwdata[15:0];
				`GLOMC_IDX_FRAMEDLY: frame_delay_lines_r <= pwdata[15:0];
				`GLOMC_IDX_PHASE:    subpixel_phase_shift_r <= pwdata[15:0];
				`GLOMC_IDX_CTRL:     ctrl_r <= pwdata[2:0];
				`GLOMC_IDX_CUSTOM:   custom_r <= custom_r | pwdata[1:0]; // see R20
				default:             ctrl_r <= ctrl_r;
			endcase
		end
	end

	// Read mux, registered data
	always @(posedge clk_sys)
	begin
		if (!resetn)
			prdata <= 32'h0000_0000;
		else if (clk_en && psel && !penable && !pwrite)
		begin
			case (widx)
				`GLOMC_IDX_STATUS:   prdata <= {27'h000_0000,
					vlock_r & ~dip, vlock_r & ~dip, ref_ok & (state_r == ST_LOCK),
					1'b0, ref_ok};
				`GLOMC_IDX_LINEDLY:  prdata <= {16'h0000, line_delay_pixels_r};
				`GLOMC_IDX_FRAMEDLY: prdata <= {16'h0000, frame_delay_lines_r};
				`GLOMC_IDX_PHASE:    prdata <= {16'h0000, subpixel_phase_shift_r};
				`GLOMC_IDX_SAECOUNT: prdata <= {16'h0000, sae_count_in}; // see R10
				`GLOMC_IDX_CTRL:     prdata <= {29'h0000_0000, ctrl_r};
				`GLOMC_IDX_MODE:     prdata <= {19'h0_0000, 1'b0, audio_rate, active_format,
					state_r};
				`GLOMC_IDX_CUSTOM:   prdata <= {30'h0000_0000, custom_r};
				default:             prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Pin synchronisers and edge history
	always @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			hs_s1_r <= 3'b100;
			hs_s2_r <= 3'b100;
			hs_d_r  <= 1'b0;
			vs_d_r  <= 1'b0;
		end
		else if (clk_en)
		begin
			hs_s1_r <= {lock_req_n, ref_vsync, ref_hsync};
			hs_s2_r <= hs_s1_r;
			hs_d_r  <= hs_s2_r[0];
			vs_d_r  <= hs_s2_r[1];
		end
	end

	// Reference presence: lines must keep arriving
	always @(posedge clk_sys)
	begin
		if (!resetn)
			loss_cnt_r <= LOSS_CYC[17:0];
		else if (clk_en)
		begin
			if (h_edge)
				loss_cnt_r <= 18'h0_0000;
			else if (loss_cnt_r < LOSS_CYC[17:0])
				loss_cnt_r <= loss_cnt_r + 18'h0_0001;
		end
	end

	// Mode machine
	always @*
	begin
		state_nxt = state_r;
		case (state_r)
			ST_START:
				if (fmt == `GLOMC_FMT_FOLLOW)
					state_nxt = ST_WAIT;                  // see R21
				else if (!lockreq)
					state_nxt = ST_FREE;                  // see R18
				else
					state_nxt = ST_LOCK;
			ST_WAIT:
				if (ref_ok && ref_fmt_valid)
					state_nxt = lockreq ? ST_LOCK : ST_FREE;
			ST_FREE:
				if (lockreq)
					state_nxt = ST_LOCK;
			ST_LOCK:
				if (!lockreq)
					state_nxt = ST_FREE;                  // see R14
				else if (!ref_ok && vlock_r)
					state_nxt = ST_HOLD;                  // see R12
			ST_HOLD:
				if (!lockreq)
					state_nxt = ST_FREE;
				else if (ref_ok)
					state_nxt = ST_LOCK;
			default:
				state_nxt = ST_START;
		endcase
	end

	always @(posedge clk_sys)
	begin
		if (!resetn)
			state_r <= ST_START;
		else if (clk_en)
			state_r <= state_nxt;
	end

	// Mode outputs and live select sampling
	always @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			clk_source       <= 2'd0;
			active_format    <= 6'h00;
			use_defaults     <= 1'b1;
			audio_rate       <= 3'd0;
			audio_lock_video <= 1'b1;
		end
		else if (clk_en)
		begin
			// Crystal in free run, reference when locked, crystal-held in hold
			case (state_r)
				ST_LOCK: clk_source <= 2'd1;          // see R23
				ST_HOLD: clk_source <= 2'd2;          // see R13
				default: clk_source <= 2'd0;          // see R14
			endcase
			audio_lock_video <= 1'b1;                 // see R15
			audio_rate       <= asr_s2_r;             // see R17 see R22
			if (fmt == `GLOMC_FMT_FOLLOW)
				active_format <= ref_fmt_valid ? ref_fmt : 6'h00; // see R21
			else
				active_format <= fmt;                 // see R22
			// Defaults when locking without reference or custom unwritten
			if (state_r == ST_WAIT)
				use_defaults <= 1'b1;
			else if (fmt == `GLOMC_FMT_CUSTOM)
				use_defaults <= ~custom_r[0];         // see R20
			else
				use_defaults <= (state_r == ST_LOCK) & ~ref_ok; // see R19
		end
	end

	// Horizontal delay: two fixed pixels then offset, never an advance
	always @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			fix_r     <= 2'b00;
			hcnt_r    <= 16'h0000;
			hpend_r   <= 1'b0;
			out_hsync <= 1'b0;
		end
		else if (clk_en && pclk_en)
		begin
			fix_r     <= {fix_r[0], h_edge};          // see R06
			out_hsync <= 1'b0;
			if (fix_r[1])
			begin
				hcnt_r  <= 16'h0000;
				hpend_r <= 1'b1;
				if (line_delay_pixels_r == 16'h0000)
				begin
					out_hsync <= 1'b1;
					hpend_r   <= 1'b0;
				end
			end
			else if (hpend_r)
			begin
				hcnt_r <= hcnt_r + 16'h0001;
				if (hcnt_r + 16'h0001 == line_delay_pixels_r) // see R04 see R25
				begin
					out_hsync <= 1'b1;
					hpend_r   <= 1'b0;
				end
			end
		end
	end

	// Vertical delay in output lines after reference frame
	always @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			vcnt_r    <= 16'h0000;
			vpend_r   <= 1'b0;
			out_vsync <= 1'b0;
			vlock_r   <= 1'b0;
		end
		else if (clk_en)
		begin
			if (v_edge)
			begin
				vcnt_r  <= 16'h0000;
				vpend_r <= 1'b1;
				vlock_r <= ref_ok;
			end
			else if (vpend_r && out_hsync)
			begin
				vcnt_r <= vcnt_r + 16'h0001;
				if (vcnt_r == vtarget)                 // see R04
				begin
					out_vsync <= 1'b1;
					vpend_r   <= 1'b0;
				end
			end
			else if (out_hsync)
				out_vsync <= 1'b0;
			if (!ref_ok && state_r != ST_HOLD)
				vlock_r <= 1'b0;
		end
	end

	// Bit 15 repeats the top step bit inverted; it is not checked
	wire [15:0] pword = subpixel_phase_shift_r; // Phase word alias

	// Phase word decode; zero word gives zero delay
	always @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			phase_steps <= 9'h000;
			phase_scale <= 2'd0;
		end
		else if (clk_en)
		begin
			if (subpixel_phase_shift_r == 16'h0000)
			begin
				phase_steps <= 9'h000;                // see R01
				phase_scale <= 2'd0;
			end
			else if (pword[12])
			begin
				// Coarser scales split the step bits around a zero gap
				phase_steps <= {3'b000, pword[8:7], pword[3:0]}; // see R24
				phase_scale <= 2'd3;
			end
			else if (pword[11])
			begin
				phase_steps <= {2'b00, pword[8:6], pword[3:0]};
				phase_scale <= 2'd2;
			end
			else if (pword[10])
			begin
				phase_steps <= {1'b0, pword[8:5], pword[3:0]};
				phase_scale <= 2'd1;
			end
			else
			begin
				phase_steps <= subpixel_phase_shift_r[8:0];
				phase_scale <= 2'd0;
			end
		end
	end

endmodule // glomc_top

// ### core/glomc_defs.vh
// Constants for the genlock offset and mode control block.
// Assumes an APB master on clk_sys with word-aligned 32-bit registers.
//
// How it works
// R01 - Zero phase word gives no sub-pixel delay
// R02 - Host keeps line delay within line length
// R03 - Host keeps frame delay within frame length
// R04 - Offsets only ever delay outputs
// R05 - Host forms advance as maximum minus advance
// R06 - Fixed two pixel delay on all timing
// R07 - One line advance except formats 4,6,8
// R08 - Cross-lock skew delays line-based outputs
// R09 - Sync refs: offset above 20 advances line
// R10 - Blanking refs: above count plus 20 advances
// R11 - Host sums all corrections independently
// R12 - Reference loss while locked enters hold; code enters hold only once a frame pulse has set vlock_r, else stays locked
// R13 - Hold frequency follows crystal drift
// R14 - Lock-request high means free run
// R15 - Audio clock follows video in free run
// R16 - Host sets select pins after power-up
// R17 - Format and audio rate select inputs
// R18 - Formats 1-51 check lock-request pin at start
// R19 - No reference: outputs may use defaults
// R20 - Format 62 custom timing until written; code gives defaults (use_defaults) until custom bit 0 is written
// R21 - Format 63 waits for reference then follows
// R22 - Select pins sampled continuously
// R23 - Locked outputs follow reference
// R24 - Phase shift step set by clock rate
// R25 - Timing delayed by horizontal offset
`ifndef GLOMC_DEFS_VH
`define GLOMC_DEFS_VH

// Register word indices; the APB byte address is four times the index
`define GLOMC_IDX_STATUS    8'h16
`define GLOMC_IDX_LINEDLY   8'h1B
`define GLOMC_IDX_FRAMEDLY  8'h1C
`define GLOMC_IDX_PHASE     8'h1D
`define GLOMC_IDX_SAECOUNT  8'h51
`define GLOMC_IDX_CTRL      8'h60
`define GLOMC_IDX_MODE      8'h61
`define GLOMC_IDX_CUSTOM    8'h62

// Status bit positions
`define GLOMC_ST_REFOK      0
`define GLOMC_ST_HLOCK      2
`define GLOMC_ST_VLOCK      3
`define GLOMC_ST_FLOCK      4

// Control bit positions
`define GLOMC_CT_BLANKREF   0
`define GLOMC_CT_MASKLOCK   1
`define GLOMC_CT_XLOCK      2

// Formats
`define GLOMC_FMT_CUSTOM    6'h3E
`define GLOMC_FMT_FOLLOW    6'h3F
`define GLOMC_FMT_LASTSTD   6'h33

// Fixed corrections
`define GLOMC_FIXED_PIX     16'h0002
`define GLOMC_HTHRESH       16'h0014
`define GLOMC_SAE_DEFAULT   16'h0000

// Timing: reference considered lost after this many ns without a line
`define GLOMC_LOSS_NS       100000
`define GLOMC_CLK_MHZ       40

`endif

// ### bench/glomc_checker.sv
// Port-level checker for the genlock offset and mode control block.
// Assumes one clock, clk_sys, and a synchronous active-low reset.
`timescale 1ns/1ps
module glomc_checker (
	input wire        clk_sys,              // System clock
	input wire        resetn,               // Sync reset, active low
	input wire        ref_hsync,            // Reference line pulse
	input wire        lock_req_n,           // Lock-request pin
	input wire [5:0]  output_format_select, // Format select pins
	input wire [2:0]  audio_rate_select,    // Audio rate pins
	input wire [15:0] sae_count_in,         // Count behind 0x51
	input wire [9:0]  paddr,                // APB byte address
	input wire        psel,                 // APB select
	input wire        penable,              // APB enable
	input wire        pwrite,               // APB direction
	input wire [31:0] pwdata,               // APB write data
	input wire [31:0] prdata,               // APB read data
	input wire        out_hsync,            // Delayed line pulse
	input wire [8:0]  phase_steps,          // Sub-pixel steps
	input wire [1:0]  clk_source,           // Clock source state
	input wire        use_defaults,         // Default timing flag
	input wire [2:0]  audio_rate,           // Active audio rate
	input wire        audio_lock_video      // Audio tracks video
);
	localparam int HS_LAT = 5; // Two sync stages, two fixed pixels, output flop
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	wire       wr = psel & penable & pwrite; // Write taken this edge
	reg [15:0] dly_r;                         // Last line delay written
	reg [15:0] cnt_r;                         // Cycles since reference edge
	reg [7:0]  lk_r;                          // Lock age, saturating
	reg        ref_q_r;                       // Previous reference level
	reg        cust_r;                        // Custom timing written
	// Track delay, reference edge age and lock age
	always @(posedge clk_sys)
	begin
		ref_q_r <= ref_hsync;
		if (!resetn)
		begin
			dly_r <= 16'h0000;
			cnt_r <= 16'h0000;
			lk_r <= 8'h00;
			cust_r <= 1'b0;
		end
		else
		begin
			if (wr && paddr == 10'h06C)
				dly_r <= pwdata[15:0];
			if (wr && paddr == 10'h188 && pwdata[0])
				cust_r <= 1'b1;
			// A new delay voids the pulse in flight, so clear the count until the next edge
			if (wr && paddr == 10'h06C)
				cnt_r <= 16'h0000;
			else if (ref_hsync && !ref_q_r)
				cnt_r <= 16'h0001;
			else if (cnt_r != 16'h0000 && cnt_r != 16'hFFFF)
				cnt_r <= cnt_r + 16'h0001;
			lk_r <= (clk_source != 2'd1) ? 8'h00 : (lk_r == 8'hFF) ? lk_r : lk_r + 8'h01;
		end
	end
	sequence s_phase0;
		wr && paddr == 10'h074 && pwdata[15:0] == 16'h0000;
	endsequence
	sequence s_quiet;
		!(wr && paddr == 10'h074) [*3];
	endsequence
	sequence s_rd_setup(a);
		psel && !penable && !pwrite && paddr == a;
	endsequence
	a_phase_zero: assert property (s_phase0 ##1 s_quiet |-> phase_steps == 9'h000)
		else $error("phase steps not zero after zero phase word");
	a_hs_early: assert property (lk_r == 8'hFF && cnt_r != 0 && cnt_r < HS_LAT + dly_r |-> !out_hsync)
		else $error("line pulse ahead of programmed delay");
	a_hs_on_time: assert property (lk_r == 8'hFF && cnt_r == HS_LAT + dly_r |-> out_hsync)
		else $error("line pulse missing at programmed delay");
	a_free_run: assert property (lock_req_n [*8] |-> clk_source == 2'd0)
		else $error("crystal not selected with lock request high");
	a_audio_lock: assert property (clk_source == 2'd0 |-> audio_lock_video)
		else $error("audio not tracking video in free run");
	a_audio_follow: assert property ((lock_req_n && $stable(audio_rate_select)) [*4] |-> audio_rate == audio_rate_select)
		else $error("audio rate does not follow pins");
	a_custom_dflt: assert property ((output_format_select == 6'h3E && !cust_r) [*4] |-> use_defaults)
		else $error("custom format left defaults early");
	a_rd_count: assert property (s_rd_setup(10'h144) |=> prdata == {16'h0000, $past(sae_count_in)})
		else $error("count register read wrong");
	a_rd_unmapped: assert property (s_rd_setup(10'h100) |=> prdata == 32'h0000_0000)
		else $error("unmapped read not zero");
endmodule // glomc_checker
bind glomc_top glomc_checker u_chk (.clk_sys, .resetn, .ref_hsync, .lock_req_n,
	.output_format_select, .audio_rate_select, .sae_count_in, .paddr, .psel, .penable,
	.pwrite, .pwdata, .prdata, .out_hsync, .phase_steps, .clk_source, .use_defaults,
	.audio_rate, .audio_lock_video);

// ### bench/glomc_ref_model.sv
// Video reference source: line pulses every PERIOD cycles while enabled.
// Assumes it is clocked by clk_sys; outputs change just after the edge.
`timescale 1ns/1ps
module glomc_ref_model #(
	parameter [15:0] PERIOD = 16'h00C8, // Line length in cycles
	parameter [5:0]  FMT    = 6'h04     // Format reported while present
) (
	input  wire       clk_sys,       // Clock
	input  wire       en,            // Reference present
	output reg        ref_hsync,     // Line pulse
	output reg        ref_vsync,     // Frame pulse, every fourth line
	output reg        ref_fmt_valid, // Format recognised
	output reg  [5:0] ref_fmt        // Detected format
);
	reg [15:0] cnt_r = 16'h0000; // Position in line
	reg [1:0]  ln_r  = 2'b00;    // Line in frame
	initial {ref_hsync, ref_vsync, ref_fmt_valid, ref_fmt} = 9'h000;
	// Removed reference shows no stale format: inverted code instead
	always @(posedge clk_sys)
	begin
		cnt_r <= (cnt_r == PERIOD - 16'h0001) ? 16'h0000 : cnt_r + 16'h0001;
		if (cnt_r == 16'h0000)
			ln_r <= ln_r + 2'b01;
		ref_hsync <= en && cnt_r == 16'h0000;
		ref_vsync <= en && cnt_r == 16'h0000 && ln_r == 2'b00;
		ref_fmt_valid <= en;
		ref_fmt <= en ? FMT : ~FMT;
	end
endmodule // glomc_ref_model

// ### bench/test_genlock_offset_mode_control.sv
// Self-checking bench: APB host, reference model, register model.
// Assumes the checker is bound to the design by its own file.
`timescale 1ns/1ps
module test_genlock_offset_mode_control;
	reg         clk_sys = 0, resetn = 0, lock_req_n = 1, ref_en = 0;
	reg         psel = 0, penable = 0, pwrite = 0;
	reg  [5:0]  output_format_select = 6'h01;
	reg  [2:0]  audio_rate_select    = 3'h0;
	reg  [15:0] sae_count_in         = 16'h0000;
	reg  [9:0]  paddr                = 10'h000;
	reg  [31:0] pwdata = 32'h0000_0000, q, seed = 32'h9c69_c5b0;
	wire        pready, pslverr, out_hsync, out_vsync, use_defaults, audio_lock_video;
	wire        ref_hsync, ref_vsync, ref_fmt_valid;
	wire [5:0]  ref_fmt, active_format;
	wire [31:0] prdata;
	wire [8:0]  phase_steps;
	wire [1:0]  phase_scale, clk_source;
	wire [2:0]  audio_rate;
	integer     bad_count = 0, num_checks = 0, i, j, n;
	integer     mdl [0:255];                             // Register model
	reg  [7:0]  adr [0:4] = '{8'h1B, 8'h1C, 8'h1D, 8'h40, 8'h51};
	reg  [5:0]  fmts [0:2] = '{6'h01, 6'h04, 6'h33};
	reg  [15:0] dlys [0:3] = '{16'h0000, 16'h0007, 16'h0014, 16'h0021};
	glomc_top uut (.clk_sys, .resetn, .clk_en(1'b1), .pclk_en(1'b1), .ref_hsync, .ref_vsync,
		.ref_fmt_valid, .ref_fmt, .lock_req_n, .output_format_select, .audio_rate_select,
		.sae_count_in, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .prdata, .pslverr,
		.out_hsync, .out_vsync, .phase_steps, .phase_scale, .clk_source, .active_format,
		.use_defaults, .audio_rate, .audio_lock_video);
	glomc_ref_model ref_src (.clk_sys, .en(ref_en), .ref_hsync, .ref_vsync, .ref_fmt_valid,
		.ref_fmt);
	always #12.5 clk_sys = ~clk_sys; // 40 MHz
	function [31:0] xs(input [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		xs = s ^ (s << 5);
	endfunction
	task chk(input string nm, input [31:0] e, input [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One APB transfer; held until pready is seen high at an edge
	task apb(input [7:0] a, input w, input [31:0] d);
		integer k;
		psel <= 1;
		penable <= 0;
		paddr <= {a, 2'b00}; // Word index to byte address
		pwrite <= w;
		pwdata <= d;
		@(posedge clk_sys) penable <= 1;
		k = 0;
		@(posedge clk_sys);
		while (pready !== 1'b1 && k < 20)
		begin
			k++;
			@(posedge clk_sys);
		end
		chk("pready", 1, pready);
		chk("pslverr", 0, pslverr);
		q = prdata;
		psel <= 0;
		penable <= 0;
		if (w && (a == 8'h1B || a == 8'h1C || a == 8'h1D))
			mdl[a] = d[15:0]; // Only the low half word is stored
		@(posedge clk_sys);
	endtask
	// Read and compare with the model; unmapped places read zero
	task rd(input [7:0] a);
		apb(a, 0, 0);
		chk("register", (a == 8'h51) ? sae_count_in : (a == 8'h40) ? 0 : mdl[a], q);
	endtask
	task wait_src(input [1:0] s, input integer lim);
		n = 0;
		while (clk_source !== s && n < lim)
		begin
			n++;
			@(posedge clk_sys);
		end
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		#(25 * 40000);
		bad_count++;
		summarize;
	end
	initial
	begin
		for (i = 0; i < 256; i++)
			mdl[i] = 0;
		repeat (2) @(posedge clk_sys);
		chk("use_defaults", 1, use_defaults);
		chk("audio_lock_video", 1, audio_lock_video);
		chk("clk_source", 0, clk_source);
		resetn <= 1;
		@(posedge clk_sys);
		for (i = 0; i < 5; i++)
			rd(adr[i]);
		$display("reset test done");
		// Random writes to the five test addresses, upper bits included, then read back
		for (j = 0; j < 4; j++)
		begin
			for (i = 0; i < 5; i++)
			begin
				seed = xs(seed);
				sae_count_in <= seed[31:16];
				apb(adr[i], 1, seed);
			end
			for (i = 0; i < 5; i++)
				rd(adr[i]);
		end
		apb(8'h1D, 1, 32'h0000_0545); // 1/256 scale, 0xA5 steps
		repeat (4) @(posedge clk_sys);
		chk("phase_steps", 9'h0A5, phase_steps);
		chk("phase_scale", 1, phase_scale);
		apb(8'h1D, 1, 0);
		repeat (4) @(posedge clk_sys);
		chk("phase_steps", 0, phase_steps);
		$display("register test done");
		// Free run: every audio rate, several formats
		for (i = 0; i < 8; i++)
		begin
			audio_rate_select <= i[2:0];
			output_format_select <= fmts[i % 3];
			repeat (8) @(posedge clk_sys);
			chk("audio_rate", i, audio_rate);
			chk("active_format", fmts[i % 3], active_format);
			chk("clk_source", 0, clk_source);
			chk("audio_lock_video", 1, audio_lock_video);
		end
		output_format_select <= 6'h3E;
		repeat (8) @(posedge clk_sys);
		chk("use_defaults", 1, use_defaults);
		apb(8'h62, 1, 3);
		repeat (8) @(posedge clk_sys);
		chk("use_defaults", 0, use_defaults);
		$display("mode test done");
		// Genlock, then offsets measured from reference edge to line pulse
		output_format_select <= 6'h04;
		ref_en <= 1;
		lock_req_n <= 0;
		wait_src(2'd1, 5000);
		chk("clk_source", 1, clk_source);
		apb(8'h1C, 1, 1);
		// Let a frame pulse with a live reference set the vertical lock
		repeat (1200) @(posedge clk_sys);
		for (i = 0; i < 4; i++)
		begin
			apb(8'h1B, 1, dlys[i]);
			@(posedge clk_sys);
			while (ref_hsync !== 1'b1)
				@(posedge clk_sys);
			n = 0;
			do
			begin
				@(posedge clk_sys);
				n++;
			end
			while (out_hsync !== 1'b1 && n < 500);
			chk("line delay", 5 + dlys[i], n);
			if (dlys[i] == 16'h0014)
			begin
				rd(8'h1B);
				apb(8'h16, 0, 0);
				chk("lock flags", 0, q[4:3]);
				apb(8'h60, 1, 2);
				apb(8'h16, 0, 0);
				chk("masked flags", 3, q[4:3]);
				apb(8'h60, 1, 0);
				// Blanking reference: threshold moves to count plus 20
				sae_count_in <= 16'h0005;
				apb(8'h60, 1, 1);
				apb(8'h16, 0, 0);
				chk("blank ref flags", 3, q[4:3]);
				apb(8'h60, 1, 0);
			end
		end
		n = 0;
		while (out_vsync !== 1'b1 && n < 1000)
		begin
			n++;
			@(posedge clk_sys);
		end
		chk("out_vsync", 1, out_vsync);
		$display("offset test done");
		// Reference removed: hold after the loss time, then free run
		ref_en <= 0;
		wait_src(2'd2, 6000);
		chk("hold entry", 1, n >= 3700 && n <= 4300);
		lock_req_n <= 1;
		repeat (8) @(posedge clk_sys);
		chk("clk_source", 0, clk_source);
		$display("hold test done");
		// Follow mode: reset with format 63 and no reference, then apply one
		output_format_select <= 6'h3F;
		lock_req_n <= 0;
		resetn <= 0;
		repeat (2) @(posedge clk_sys);
		resetn <= 1;
		repeat (8) @(posedge clk_sys);
		chk("use_defaults", 1, use_defaults);
		chk("clk_source", 0, clk_source);
		ref_en <= 1;
		wait_src(2'd1, 1000);
		chk("clk_source", 1, clk_source);
		chk("active_format", 4, active_format);
		$display("follow test done");
		summarize;
	end
endmodule // test_genlock_offset_mode_control
